// File: fsf_fifo_core.sv
// fifo core with empty/full, partial flags, half-full and daisy-chain cascade
// assumes write and read logic share clk_sys; config and cascade pins are asynchronous
`timescale 1ns/10ps

// Contract
// - standard mode: almost-empty low when count at or below n.
// - fall-through mode: almost-empty low when count at or below n plus one.
// - unprogrammed empty offset defaults to 31, 63 or 127 by depth.
// - async almost-empty asserts on a read, releases on a write.
// - sync almost-empty modes update the flag on read-side edges only.
// - sync almost-empty release may lag one extra read cycle.
// - async almost-full asserts on a write, clears on a read.
// - half-full goes low on the write after half the memory fills.
// - half-full returns high on a read once count is at most half.
// - write cascade output carries half-full outside daisy chain use.
// - daisy chain: pulse write cascade output on writing last location.
// - daisy chain: pulse read cascade output on reading last location.
// - read data is presented on an 18-bit output.
// - single-buffered flags for codes 000, 011, 100, 111.
// - single-buffered full flag may release one write edge late.
// - single-buffered empty flag may release one read edge late.
// - first word readable the read cycle after empty flag rises.
// - empty release latency one period, two when clocks crowd.
// - offset load writes empty offset, then full offset, then wraps.
// - fall-through: first word appears on third read edge without request.
module fsf_fifo_core #(
    parameter int DEPTH = fsf_pkg::DEPTH_DEF
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic device_reset_n,
    input wire logic first_in_chain_n,
    input wire logic read_cascade_in_n,
    input wire logic write_cascade_in_n,
    input wire logic offset_load_n,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [fsf_pkg::DATA_W-1:0] wr_data,
    input wire logic rd_en_n,
    output logic [fsf_pkg::DATA_W-1:0] read_data_out,
    output logic empty_flag_n,
    output logic full_flag_n,
    output logic almost_empty_flag_n,
    output logic almost_full_flag_n,
    output logic write_cascade_out_n,
    output logic read_cascade_out_n
);
    import fsf_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int NPIN = 4;
    localparam logic [AW-1:0] LAST_LOC = AW'(DEPTH - 1);
    localparam logic [CMP_W-1:0] DEPTH_C = CMP_W'(DEPTH);
    localparam logic [CMP_W-1:0] HALF_C = CMP_W'(DEPTH / 2);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [NPIN-1:0] pin_raw;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;

    assign pin_raw = {device_reset_n, first_in_chain_n, read_cascade_in_n, write_cascade_in_n};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clk_sys or negedge rstn) begin
                if (!rstn) begin
                    pin_s1_q[gi] <= PIN_RST;
                    pin_s2_q[gi] <= PIN_RST;
                end else begin
                    pin_s1_q[gi] <= pin_raw[gi];
                    pin_s2_q[gi] <= pin_s1_q[gi];
                end
            end
        end
    endgenerate

    logic dev_rst;
    logic wxi_low;
    logic rxi_low;
    assign dev_rst = ~pin_s2_q[3];
    assign rxi_low = ~pin_s2_q[1];
    assign wxi_low = ~pin_s2_q[0];

    // ------------------------------------------------------------------
    // mode capture
    // ------------------------------------------------------------------
    fsf_mode_type mode_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_q <= MODE_RST;
        end else if (dev_rst) begin
            mode_q <= fsf_decode(pin_s2_q[2:0]);
        end
    end

    // ------------------------------------------------------------------
    // offset registers
    // ------------------------------------------------------------------
    fsf_offsets_type ofs_q;
    fsf_ofs_sel_type ofs_sel_q;
    logic ofs_wr;

    assign ofs_wr = ~offset_load_n && wr_valid && ~dev_rst;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ofs_q <= '{empty_ofs: fsf_default_offset(DEPTH), full_ofs: fsf_default_offset(DEPTH)};
            ofs_sel_q <= OFS_SEL_EMPTY;
        end else if (dev_rst) begin
            ofs_q <= '{empty_ofs: fsf_default_offset(DEPTH), full_ofs: fsf_default_offset(DEPTH)};
            ofs_sel_q <= OFS_SEL_EMPTY;
        end else if (ofs_wr) begin
            case (ofs_sel_q)
                OFS_SEL_EMPTY: begin
                    ofs_q.empty_ofs <= wr_data[OFFSET_W-1:0];
                    ofs_sel_q <= OFS_SEL_FULL;
                end
                OFS_SEL_FULL: begin
                    ofs_q.full_ofs <= wr_data[OFFSET_W-1:0];
                    ofs_sel_q <= OFS_SEL_EMPTY;
                end
                default: begin
                    ofs_sel_q <= OFS_SEL_EMPTY;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // write path through the skid buffer
    // ------------------------------------------------------------------
    logic sk_in_valid;
    logic sk_in_ready;
    logic sk_valid;
    logic sk_ready;
    logic [DATA_W-1:0] sk_data;

    assign sk_in_valid = wr_valid && offset_load_n && ~dev_rst;
    assign wr_ready = ~dev_rst && (offset_load_n ? sk_in_ready : 1'b1);

    fsf_skid_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(SKID_DEPTH)
    ) u_skid (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .in_valid(sk_in_valid),
        .in_ready(sk_in_ready),
        .in_data(wr_data),
        .out_valid(sk_valid),
        .out_ready(sk_ready),
        .out_data(sk_data)
    );

    // ------------------------------------------------------------------
    // pointers and their delayed views
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [AW:0] wptr_q;
    logic [AW:0] rptr_q;
    logic [AW:0] wptr_d1_q;
    logic [AW:0] wptr_d2_q;
    logic [AW:0] rptr_d1_q;
    logic [AW:0] rptr_d2_q;
    logic [AW:0] wview;
    logic [AW:0] rview;
    logic wr_tok_q;
    logic rd_tok_q;
    logic out_valid_q;
    logic do_write;
    logic pop;
    logic full_now;
    logic mem_empty_r;
    logic rd_req;

    // each side sees the other's pointer through registers
    // single-buffered full may lag one edge
    // single-buffered empty may lag one edge
    assign wview = mode_q.single_buf ? wptr_d1_q : wptr_d2_q;
    assign rview = mode_q.single_buf ? rptr_d1_q : rptr_d2_q;
    assign full_now = ((wptr_q - rview) == (AW+1)'(DEPTH));
    assign mem_empty_r = (wview == rptr_q);

    assign do_write = sk_valid && ~full_now && offset_load_n && ~dev_rst && (~mode_q.daisy || wr_tok_q);
    assign sk_ready = do_write;

    assign rd_req = ~rd_en_n && offset_load_n && ~dev_rst && (~mode_q.daisy || rd_tok_q);

    // fall-through refills the output stage unasked
    // standard read pops only when flagged non-empty
    always_comb begin
        if (mode_q.fall_through) begin
            pop = ~mem_empty_r && ~dev_rst && (~out_valid_q || rd_req);
        end else begin
            pop = ~mem_empty_r && rd_req;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (do_write) begin
            mem_q[wptr_q[AW-1:0]] <= sk_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else if (dev_rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
        end else begin
            wptr_q <= wptr_q + (AW+1)'(do_write);
            rptr_q <= rptr_q + (AW+1)'(pop);
        end
    end

    // one or two stages of latency
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wptr_d1_q <= '0;
            wptr_d2_q <= '0;
            rptr_d1_q <= '0;
            rptr_d2_q <= '0;
        end else if (dev_rst) begin
            wptr_d1_q <= '0;
            wptr_d2_q <= '0;
            rptr_d1_q <= '0;
            rptr_d2_q <= '0;
        end else begin
            wptr_d1_q <= wptr_q;
            wptr_d2_q <= wptr_d1_q;
            rptr_d1_q <= rptr_q;
            rptr_d2_q <= rptr_d1_q;
        end
    end

    // ------------------------------------------------------------------
    // read data output
    // ------------------------------------------------------------------
    // 18-bit output register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            read_data_out <= '0;
        end else if (pop) begin
            read_data_out <= mem_q[rptr_q[AW-1:0]];
        end
    end

    // the previous word stays on the outputs after the last one is taken
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            out_valid_q <= 1'b0;
        end else if (dev_rst || ~mode_q.fall_through) begin
            out_valid_q <= 1'b0;
        end else if (pop) begin
            out_valid_q <= 1'b1;
        end else if (rd_req) begin
            out_valid_q <= 1'b0;
        end
    end

    assign empty_flag_n = mode_q.fall_through ? ~out_valid_q : ~mem_empty_r;
    assign full_flag_n = mode_q.fall_through ? full_now : ~full_now;

    // ------------------------------------------------------------------
    // occupancy for partial flags
    // ------------------------------------------------------------------
    logic [CMP_W-1:0] cnt_next;
    logic [CMP_W-1:0] cnt_rview;
    logic [CMP_W-1:0] cnt_wview;
    logic [CMP_W-1:0] ae_thr;
    logic [CMP_W-1:0] af_thr;
    logic ov_next;
    logic [AW:0] wptr_n;
    logic [AW:0] rptr_n;

    assign wptr_n = wptr_q + (AW+1)'(do_write);
    assign rptr_n = rptr_q + (AW+1)'(pop);
    assign ov_next = mode_q.fall_through && (pop || (out_valid_q && ~rd_req));
    assign cnt_next = CMP_W'(wptr_n - rptr_n) + CMP_W'(ov_next);
    assign cnt_rview = CMP_W'(wview - rptr_q) + CMP_W'(out_valid_q);
    assign cnt_wview = CMP_W'(wptr_q - rview) + CMP_W'(out_valid_q);

    // threshold n plus one in fall-through
    assign ae_thr = CMP_W'(ofs_q.empty_ofs) + CMP_W'(mode_q.fall_through);
    assign af_thr = DEPTH_C + CMP_W'(mode_q.fall_through) - CMP_W'(ofs_q.full_ofs);

    // ------------------------------------------------------------------
    // almost-empty
    // ------------------------------------------------------------------
    logic ae_n_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ae_n_q <= AE_RST;
        end else if (dev_rst) begin
            ae_n_q <= AE_RST;
        end else if (mode_q.sync_partial) begin
            ae_n_q <= ~(cnt_rview <= ae_thr);
        end else if (do_write && ~(cnt_next <= ae_thr)) begin
            ae_n_q <= 1'b1;
        end else if (pop && (cnt_next <= ae_thr)) begin
            ae_n_q <= 1'b0;
        end
    end

    assign almost_empty_flag_n = ae_n_q;

    // ------------------------------------------------------------------
    // almost-full
    // ------------------------------------------------------------------
    logic af_n_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            af_n_q <= AF_RST;
        end else if (dev_rst) begin
            af_n_q <= AF_RST;
        end else if (mode_q.sync_partial) begin
            af_n_q <= ~(cnt_wview >= af_thr);
        end else if (do_write && (cnt_next >= af_thr)) begin
            af_n_q <= 1'b0;
        end else if (pop && ~(cnt_next >= af_thr)) begin
            af_n_q <= 1'b1;
        end
    end

    assign almost_full_flag_n = af_n_q;

    // ------------------------------------------------------------------
    // half-full
    // ------------------------------------------------------------------
    logic hf_n_q;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hf_n_q <= HF_RST;
        end else if (dev_rst) begin
            hf_n_q <= HF_RST;
        end else if (do_write && (cnt_next > HALF_C)) begin
            hf_n_q <= 1'b0;
        end else if (pop && (cnt_next <= HALF_C)) begin
            // high on read at or below half
            hf_n_q <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // daisy-chain cascade
    // ------------------------------------------------------------------
    logic wxo_q;
    logic rxo_q;
    logic wr_last;
    logic rd_last;

    assign wr_last = do_write && (wptr_q[AW-1:0] == LAST_LOC) && mode_q.daisy;
    assign rd_last = pop && (rptr_q[AW-1:0] == LAST_LOC) && mode_q.daisy;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wxo_q <= 1'b0;
            rxo_q <= 1'b0;
        end else begin
            wxo_q <= wr_last;
            rxo_q <= rd_last;
        end
    end

    // the token arriving wins over a token leaving in the same cycle
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_tok_q <= 1'b0;
            rd_tok_q <= 1'b0;
        end else if (dev_rst) begin
            wr_tok_q <= fsf_decode(pin_s2_q[2:0]).first_dev;
            rd_tok_q <= fsf_decode(pin_s2_q[2:0]).first_dev;
        end else begin
            if (wxi_low) begin
                wr_tok_q <= 1'b1;
            end else if (wr_last) begin
                wr_tok_q <= 1'b0;
            end
            if (rxi_low) begin
                rd_tok_q <= 1'b1;
            end else if (rd_last) begin
                rd_tok_q <= 1'b0;
            end
        end
    end

    // half-full shares the write cascade pin
    assign write_cascade_out_n = mode_q.daisy ? ~wxo_q : hf_n_q;
    assign read_cascade_out_n = ~rxo_q;

endmodule

// File: fsf_fifo_core_sva.sv
// port-level checker for the status-flag fifo core, bound to its top
// assumes the config pins are steady while the device reset pin is low
`timescale 1ns/10ps
module fsf_fifo_core_chk
    import fsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic device_reset_n,
    input wire logic first_in_chain_n,
    input wire logic read_cascade_in_n,
    input wire logic write_cascade_in_n,
    input wire logic offset_load_n,
    input wire logic wr_ready,
    input wire logic rd_en_n,
    input wire logic [fsf_pkg::DATA_W-1:0] read_data_out,
    input wire logic empty_flag_n,
    input wire logic almost_empty_flag_n,
    input wire logic almost_full_flag_n,
    input wire logic write_cascade_out_n,
    input wire logic read_cascade_out_n
);
    logic [2:0] cfg_q;
    logic [7:0] hist_q;
    // the core syncs reset and config, so checks wait out the sync delay
    wire settled = device_reset_n && (&hist_q);
    wire std_m = (cfg_q != CFG_001) && (cfg_q != CFG_101);
    wire daisy_m = (cfg_q == CFG_011) || (cfg_q == CFG_111);
    wire async_m = (cfg_q != CFG_100) && (cfg_q != CFG_101) && (cfg_q != CFG_110);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= CFG_000;
        end else if (!device_reset_n) begin
            cfg_q <= {first_in_chain_n, read_cascade_in_n, write_cascade_in_n};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            hist_q <= 8'h00;
        end else begin
            hist_q <= {hist_q[6:0], device_reset_n};
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_rd_cascade_pulse: assert property ($fell(read_cascade_out_n) |=> read_cascade_out_n)
        else $error("read cascade pulse longer than one cycle");
    a_rd_cascade_idle: assert property (settled && !daisy_m |-> read_cascade_out_n)
        else $error("read cascade active outside daisy chain");
    a_wr_cascade_pulse: assert property (settled && daisy_m && $fell(write_cascade_out_n) |=> write_cascade_out_n)
        else $error("write cascade pulse longer than one cycle");
    a_reset_flag_values: assert property (!device_reset_n [*4] |-> almost_empty_flag_n == AE_RST
        && almost_full_flag_n == AF_RST && write_cascade_out_n == HF_RST && read_cascade_out_n == PIN_RST)
        else $error("flags not at reset values during device reset");
    a_ready_in_reset: assert property (!device_reset_n [*4] |-> !wr_ready)
        else $error("write ready during device reset");
    a_load_ready: assert property (settled && !offset_load_n |-> wr_ready)
        else $error("offset load not accepted");
    a_data_needs_read: assert property (settled && std_m && $changed(read_data_out)
        |-> !$past(rd_en_n) && $past(empty_flag_n))
        else $error("read data changed without a read");
    a_hf_on_read: assert property (settled && !daisy_m && $rose(write_cascade_out_n) |-> !$past(rd_en_n))
        else $error("half-full released without a read");
    a_ae_on_read: assert property (settled && async_m && $fell(almost_empty_flag_n) |-> !$past(rd_en_n))
        else $error("almost-empty asserted without a read");

    c_rd_cascade: cover property (!read_cascade_out_n);
    c_half_full: cover property (settled && !daisy_m && !write_cascade_out_n);
    c_fall_through: cover property (settled && !std_m && !empty_flag_n);
endmodule

bind fsf_fifo_core fsf_fifo_core_chk u_chk (.*);

// File: fsf_fifo_core_test.sv
// self-checking bench for the status-flag fifo core at depth 16
// assumes the partner model feeds the write port; reads are driven here
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin fails++; \
    $display("unexpected %s exp %h got %h", nm, exp, got); end end
module fsf_fifo_core_test;
    import fsf_pkg::*;
    logic clk_sys, rstn, device_reset_n, first_in_chain_n, read_cascade_in_n, write_cascade_in_n;
    logic offset_load_n, push, rd_en_n, wr_valid, wr_ready, empty_flag_n, full_flag_n, fw;
    logic almost_empty_flag_n, almost_full_flag_n, write_cascade_out_n, read_cascade_out_n;
    logic [DATA_W-1:0] push_data, wr_data, read_data_out;
    int fails, tests_run, wx_cnt, rx_cnt;
    logic [2:0] cfg_list [5] = '{CFG_000, CFG_100, CFG_110, CFG_001, CFG_101};

    // every port name matches a bench signal of the same width
    fsf_partner u_partner (.*);
    fsf_fifo_core #(.DEPTH(16)) dut (.*);

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // cascade outputs counted per low cycle, so a stretched pulse shows up too
    always @(posedge clk_sys) begin
        if (!write_cascade_out_n) wx_cnt++;
        if (!read_cascade_out_n) rx_cnt++;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic dev_reset(input logic [2:0] cfg);
        @(posedge clk_sys);
        device_reset_n <= 1'b0;
        {first_in_chain_n, read_cascade_in_n, write_cascade_in_n} <= cfg;
        repeat (6) @(posedge clk_sys);
        device_reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        wx_cnt = 0;
        rx_cnt = 0;
    endtask

    task automatic put(input logic [DATA_W-1:0] d);
        int n;
        @(posedge clk_sys);
        push <= 1'b1;
        push_data <= d;
        @(posedge clk_sys);
        push <= 1'b0;
        #1;
        n = 0;
        while (wr_valid && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        `CHK("write_taken", 1'b1, n < 50)
    endtask

    task automatic get(input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        while (empty_flag_n !== !fw && n < 50) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (fw) `CHK("fall_through_mode_data", d, read_data_out)
        @(posedge clk_sys);
        rd_en_n <= 1'b0;
        @(posedge clk_sys);
        rd_en_n <= 1'b1;
        #1;
        if (!fw) `CHK("read_data", d, read_data_out)
    endtask

    task automatic flags(input int c);
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK("almost_empty", (c > (fw ? 3 : 2)), almost_empty_flag_n)
        `CHK("almost_full", (c < (fw ? 14 : 13)), almost_full_flag_n)
        `CHK("half_full", (c <= 8), write_cascade_out_n)
        `CHK("empty", (fw ? c == 0 : c != 0), empty_flag_n)
    endtask

    initial begin
        rstn = 1'b0;
        device_reset_n = 1'b1;
        {first_in_chain_n, read_cascade_in_n, write_cascade_in_n} = CFG_000;
        offset_load_n = 1'b1;
        push = 1'b0;
        push_data = '0;
        rd_en_n = 1'b1;
        fw = 1'b0;
        fails = 0;
        tests_run = 0;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        // ----
        // single-device modes: fill past half, then drain
        // ----
        foreach (cfg_list[i]) begin
            fw = (cfg_list[i] == CFG_001) || (cfg_list[i] == CFG_101);
            dev_reset(cfg_list[i]);
            flags(0);
            @(posedge clk_sys);
            offset_load_n <= 1'b0;
            put(18'h00005);
            put(18'h00003);
            put(18'h00002);
            @(posedge clk_sys);
            offset_load_n <= 1'b1;
            for (int k = 1; k <= 13; k++) begin
                put(18'h3A5C0 ^ 18'(k));
                flags(k);
            end
            for (int k = 1; k <= 13; k++) begin
                get(18'h3A5C0 ^ 18'(k));
                flags(13 - k);
            end
            $display("test cfg %h done", cfg_list[i]);
        end
        // ----
        // daisy chain first device, default offsets
        // ----
        fw = 1'b0;
        dev_reset(CFG_011);
        for (int k = 1; k <= 16; k++) begin
            put(18'h15000 + 18'(k));
            if (k == 15) `CHK("wr_cascade_early", 0, wx_cnt)
        end
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK("wr_cascade", 1, wx_cnt)
        `CHK("full", 1'b0, full_flag_n)
        `CHK("ae_default", 1'b0, almost_empty_flag_n)
        for (int k = 1; k <= 16; k++) begin
            get(18'h15000 + 18'(k));
        end
        repeat (6) @(posedge clk_sys);
        #1;
        `CHK("rd_cascade", 1, rx_cnt)
        $display("test daisy done");
        final_report();
    end

    // expected run is about 1350 cycles; the watchdog allows about eighteen times that
    initial begin
        repeat (25000) @(posedge clk_sys);
        fails++;
        final_report();
    end
endmodule

// File: fsf_partner.sv
// write-side partner: offers one word per request and holds it until taken
// assumes the bench raises push for one cycle and waits for the word to go
`timescale 1ns/10ps
module fsf_partner
    import fsf_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic push,
    input wire logic [fsf_pkg::DATA_W-1:0] push_data,
    input wire logic wr_ready,
    output logic wr_valid,
    output logic [fsf_pkg::DATA_W-1:0] wr_data
);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_valid <= 1'b0;
            wr_data <= '0;
        end else if (wr_valid && wr_ready) begin
            // released line shows the inverse so a stale word is never mistaken for new data
            wr_valid <= 1'b0;
            wr_data <= ~wr_data;
        end else if (push && !wr_valid) begin
            wr_valid <= 1'b1;
            wr_data <= push_data;
        end
    end
endmodule

// File: fsf_pkg.sv
// constants, mode decode and types shared by the status-flag fifo core
// assumes a single system clock; the device reset, config and cascade pins are synchronised by the core
package fsf_pkg;

    localparam int DATA_W = 18;
    localparam int OFFSET_W = 12;
    localparam int CMP_W = OFFSET_W + 2;
    localparam int DEPTH_DEF = 256;
    localparam int SKID_DEPTH = 4;
    localparam int DEPTH_SMALL = 256;
    localparam int DEPTH_MID = 512;

    // ------------------------------------------------------------------
    // default offsets when nothing was programmed
    // ------------------------------------------------------------------
    localparam logic [OFFSET_W-1:0] DEF_OFS_SMALL = 12'h01F;
    localparam logic [OFFSET_W-1:0] DEF_OFS_MID = 12'h03F;
    localparam logic [OFFSET_W-1:0] DEF_OFS_DEEP = 12'h07F;

    // ------------------------------------------------------------------
    // configuration codes {first, read cascade in, write cascade in}
    // ------------------------------------------------------------------
    localparam logic [2:0] CFG_000 = 3'h0;
    localparam logic [2:0] CFG_001 = 3'h1;
    localparam logic [2:0] CFG_011 = 3'h3;
    localparam logic [2:0] CFG_100 = 3'h4;
    localparam logic [2:0] CFG_101 = 3'h5;
    localparam logic [2:0] CFG_110 = 3'h6;
    localparam logic [2:0] CFG_111 = 3'h7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic PIN_RST = 1'b1;
    localparam logic AE_RST = 1'b0;
    localparam logic AF_RST = 1'b1;
    localparam logic HF_RST = 1'b1;

    typedef struct packed {
        logic fall_through;
        logic single_buf;
        logic sync_partial;
        logic daisy;
        logic first_dev;
    } fsf_mode_type;

    localparam fsf_mode_type MODE_RST = '{fall_through: 1'b0, single_buf: 1'b1,
                                          sync_partial: 1'b0, daisy: 1'b0, first_dev: 1'b1};

    typedef enum logic {
        OFS_SEL_EMPTY,
        OFS_SEL_FULL
    } fsf_ofs_sel_type;

    typedef struct packed {
        logic [OFFSET_W-1:0] empty_ofs;
        logic [OFFSET_W-1:0] full_ofs;
    } fsf_offsets_type;

    function automatic logic [OFFSET_W-1:0] fsf_default_offset(input int depth);
        if (depth <= DEPTH_SMALL) begin
            return DEF_OFS_SMALL;
        end else if (depth <= DEPTH_MID) begin
            return DEF_OFS_MID;
        end
        return DEF_OFS_DEEP;
    endfunction

    function automatic fsf_mode_type fsf_decode(input logic [2:0] code);
        fsf_mode_type m;
        m.fall_through = (code == CFG_001) || (code == CFG_101);
        m.single_buf = (code == CFG_000) || (code == CFG_011) || (code == CFG_100) || (code == CFG_111);
        m.sync_partial = (code == CFG_100) || (code == CFG_101) || (code == CFG_110);
        m.daisy = (code == CFG_011) || (code == CFG_111);
        m.first_dev = ~code[2];
        return m;
    endfunction

endpackage

// File: fsf_skid_fifo.sv
// small write-side buffer between the write port and the main array
// assumes one clock; depth is a power of two
`timescale 1ns/10ps
module fsf_skid_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 4
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0] wp_q;
    logic [AW:0] rp_q;
    logic full;

    assign full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign in_ready = ~full;
    assign out_valid = (wp_q != rp_q);
    assign out_data = mem_q[rp_q[AW-1:0]];

    always_ff @(posedge clk_sys) begin
        if (in_valid && in_ready) begin
            mem_q[wp_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wp_q <= '0;
        end else if (in_valid && in_ready) begin
            wp_q <= wp_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rp_q <= '0;
        end else if (out_valid && out_ready) begin
            rp_q <= rp_q + 1'b1;
        end
    end

endmodule
